// >>> include/slm_pkg.sv
// Purpose: Shared constants for the single-instruction loop mode controller.
// Assumes: 16-bit instruction words, 32-bit program counter.
// Notes:   Condition selector uses the usual sixteen-way condition encoding.
package slm_pkg;
    localparam int          WORD_W       = 16;
    localparam int          ADDR_W       = 32;
    localparam int          CC_W         = 5;
    localparam int          COND_W       = 4;
    localparam int          QUEUE_DEPTH  = 2;
    localparam logic [15:0] COUNT_EXPIRED = 16'hFFFF;
    localparam logic [15:0] LOOP_DISP     = 16'hFFFC;
    localparam logic [31:0] WORD_BYTES    = 32'h0000_0002;
    localparam int          CC_C = 0;
    localparam int          CC_V = 1;
    localparam int          CC_Z = 2;
    localparam int          CC_N = 3;
    typedef enum logic [1:0] {
        SLM_IDLE,
        SLM_ARMED,
        SLM_LOOP
    } slm_state_e;
endpackage

// >>> logic/slm_cond_eval.sv
// Purpose: Evaluates a branch condition against the condition code bits.
// Assumes: Condition code bits follow the package positions.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module slm_cond_eval
    import slm_pkg::*;
(
    input  wire logic [slm_pkg::COND_W-1:0] i_cond,
    input  wire logic [slm_pkg::CC_W-1:0]   i_ccr,
    output logic                            o_true
);
    wire c = i_ccr[CC_C];
    wire v = i_ccr[CC_V];
    wire z = i_ccr[CC_Z];
    wire n = i_ccr[CC_N];
    always_comb begin
        case (i_cond)
            4'h0:    o_true = 1'b1;
            4'h1:    o_true = 1'b0;
            4'h2:    o_true = ~c & ~z;
            4'h3:    o_true = c | z;
            4'h4:    o_true = ~c;
            4'h5:    o_true = c;
            4'h6:    o_true = ~z;
            4'h7:    o_true = z;
            4'h8:    o_true = ~v;
            4'h9:    o_true = v;
            4'hA:    o_true = ~n;
            4'hB:    o_true = n;
            4'hC:    o_true = ~(n ^ v);
            4'hD:    o_true = n ^ v;
            4'hE:    o_true = ~z & ~(n ^ v);
            default: o_true = z | (n ^ v);
        endcase
    end
endmodule
`default_nettype wire

// >>> logic/slm_loop_ctrl.sv
// Purpose: Single-instruction loop mode controller between prefetch and decode.
// Assumes: Execution unit pulses i_tdb_exec when a test_decrement_branch runs.
// Notes:   Fetch suppression is the o_fetch_en level; operand cycles are not gated.
// Notes on behaviour
// - In loop mode the looped instruction repeats with no instruction fetches.
// - The branch instruction carries a counter register, a condition and a displacement.
// - Each branch execution decrements the counter low word and compares with minus one.
// - A count of minus one is written back and execution falls through, leaving the loop.
// - Otherwise a true condition discards the count and execution falls through.
// - Otherwise the displacement is added to the program counter and the target runs.
// - Loop mode starts only for a looping minus-four branch onto a preceding one-word op.
// - On entry both instruction words are fetched a second time, then fetching stops.
// - The loop lives in the decode register plus the two-word prefetch queue.
// - Interrupts are taken only after a branch execution and taking one ends loop mode.
`timescale 1ns/1ps
`default_nettype none
module slm_loop_ctrl
    import slm_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_tdb_exec,
    input  wire logic [slm_pkg::WORD_W-1:0] i_count_lo,
    input  wire logic [slm_pkg::COND_W-1:0] i_cond,
    input  wire logic [slm_pkg::WORD_W-1:0] i_disp,
    input  wire logic [slm_pkg::ADDR_W-1:0] i_tdb_pc,
    input  wire logic [slm_pkg::CC_W-1:0]   i_ccr,
    input  wire logic                      i_prev_loopable,
    input  wire logic                      i_prev_fetched,
    input  wire logic [slm_pkg::WORD_W-1:0] i_fetch_word,
    input  wire logic                      i_fetch_valid,
    input  wire logic                      i_irq_pending,
    input  wire logic                      i_abort,
    output logic                           o_loop_active,
    output logic                           o_fetch_en,
    output logic                           o_count_wr,
    output logic [slm_pkg::WORD_W-1:0]     o_count_val,
    output logic                           o_pc_load,
    output logic [slm_pkg::ADDR_W-1:0]     o_pc_next,
    output logic                           o_irq_take,
    output logic [slm_pkg::WORD_W-1:0]     o_ird,
    output logic [slm_pkg::WORD_W-1:0]     o_queue0,
    output logic [slm_pkg::WORD_W-1:0]     o_queue1
);
    slm_state_e              state_q, state_d;
    logic                    count_wr_q, pc_load_q, irq_take_q, fetch_en_q, active_q;
    logic [WORD_W-1:0]       count_val_q;
    logic [ADDR_W-1:0]       pc_next_q;
    logic [WORD_W-1:0]       ird_q;
    logic [WORD_W-1:0]       queue_q [QUEUE_DEPTH];
    logic [1:0]              refill_q;
    logic                    cond_true;

    // Condition test on the condition selected by the branch operands.
    slm_cond_eval u_cond (
        .i_cond (i_cond),
        .i_ccr  (i_ccr),
        .o_true (cond_true)
    );

    // Branch outcome: expiry wins over the condition, and only a looping branch may arm.
    wire [WORD_W-1:0] dec_count = i_count_lo - 16'h0001;
    wire              expired   = (dec_count == COUNT_EXPIRED);
    wire              loops     = ~expired & ~cond_true;
    wire              fall      = i_tdb_exec & ~loops;
    wire              branch    = i_tdb_exec & loops;
    // Displacement is sign-extended so that minus four lands on the preceding word.
    wire [ADDR_W-1:0] disp_ext  = {{(ADDR_W-WORD_W){i_disp[WORD_W-1]}}, i_disp};
    wire [ADDR_W-1:0] tgt_pc    = i_tdb_pc + WORD_BYTES + disp_ext;
    wire [ADDR_W-1:0] seq_pc    = i_tdb_pc + WORD_BYTES + WORD_BYTES;
    wire              qualifies = branch & (i_disp == LOOP_DISP) & i_prev_loopable;
    wire              irq_now   = i_tdb_exec & i_irq_pending;
    wire              leave     = fall | irq_now | i_abort;
    wire              refill_done = (refill_q == 2'd2);

    // Armed waits for both words to be fetched again before the queue is frozen.
    always_comb begin
        state_d = state_q;
        case (state_q)
            SLM_IDLE: begin
                if (qualifies && !irq_now && !i_abort) begin
                    state_d = SLM_ARMED;
                end
            end
            SLM_ARMED: begin
                // Second fetch of looped instruction and branch opcode.
                if (leave) begin
                    state_d = SLM_IDLE;
                end else if (i_prev_fetched && refill_done) begin
                    state_d = SLM_LOOP;
                end
            end
            SLM_LOOP: begin
                if (leave) begin
                    state_d = SLM_IDLE;
                end
            end
            default: state_d = SLM_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= SLM_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Count fetched words only while armed; two arrivals mean both words came again.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            refill_q <= 2'd0;
        end else if (state_q != SLM_ARMED) begin
            refill_q <= 2'd0;
        end else if (i_fetch_valid && !refill_done) begin
            refill_q <= refill_q + 2'd1;
        end
    end

    // Loop image: looped op in decode, both branch words in the queue.
    // The image freezes in loop mode so the decode register replays the looped op.
    wire shift_en = (state_q != SLM_LOOP) & i_fetch_valid;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ird_q <= 16'h0000;
        end else if (shift_en) begin
            ird_q <= queue_q[0];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            queue_q[0] <= 16'h0000;
        end else if (shift_en) begin
            queue_q[0] <= queue_q[1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            queue_q[1] <= 16'h0000;
        end else if (shift_en) begin
            queue_q[1] <= i_fetch_word;
        end
    end

    // Result registers; every output leaves straight from a flop.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_wr_q <= 1'b0;
        end else begin
            count_wr_q <= branch | (fall & expired);
        end
    end

    // The decremented word is always presented; o_count_wr says whether it is written.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_val_q <= 16'h0000;
        end else begin
            count_val_q <= dec_count;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_load_q <= 1'b0;
        end else begin
            pc_load_q <= i_tdb_exec;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_next_q <= 32'h0000_0000;
        end else begin
            pc_next_q <= loops ? tgt_pc : seq_pc;
        end
    end

    // Interrupts are sampled only with a branch, so the looped op is never split from it.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_take_q <= 1'b0;
        end else begin
            irq_take_q <= irq_now;
        end
    end

    // Fetch stays enabled in reset so the queue fills before the first branch.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fetch_en_q <= 1'b1;
        end else begin
            fetch_en_q <= (state_d != SLM_LOOP);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            active_q <= 1'b0;
        end else begin
            active_q <= (state_d == SLM_LOOP);
        end
    end

    // Queue entries are exposed so that the loop image can be observed.
    assign o_loop_active = active_q;
    assign o_fetch_en    = fetch_en_q;
    assign o_count_wr    = count_wr_q;
    assign o_count_val   = count_val_q;
    assign o_pc_load     = pc_load_q;
    assign o_pc_next     = pc_next_q;
    assign o_irq_take    = irq_take_q;
    assign o_ird         = ird_q;
    assign o_queue0      = queue_q[0];
    assign o_queue1      = queue_q[1];
endmodule
`default_nettype wire

// >>> tb/slm_loop_properties.sv
// Purpose: Port assertions for the loop controller.
// Assumes: Condition 0 is always true and 1 never.
// Notes:   Bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module slm_loop_properties
    import slm_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_tdb_exec,
    input wire logic [15:0] i_count_lo,
    input wire logic [3:0]  i_cond,
    input wire logic [15:0] i_disp,
    input wire logic [31:0] i_tdb_pc,
    input wire logic        i_irq_pending,
    input wire logic        o_loop_active,
    input wire logic        o_fetch_en,
    input wire logic        o_count_wr,
    input wire logic [15:0] o_count_val,
    input wire logic [31:0] o_pc_next,
    input wire logic        o_irq_take,
    input wire logic [15:0] o_ird
);
    logic [31:0] disp_x;
    assign disp_x = {{16{i_disp[15]}}, i_disp};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_live;
        i_tdb_exec && i_count_lo != 16'h0000;
    endsequence
    no_fetch_a: assert property (o_loop_active |-> !o_fetch_en)
        else $error("fetch during loop");
    expire_wb_a: assert property (i_tdb_exec && i_count_lo == 16'h0000 |=> o_count_wr
        && o_count_val == 16'hFFFF && o_pc_next == $past(i_tdb_pc) + 32'h4)
        else $error("expiry wrong");
    cond_true_a: assert property (s_live ##0 i_cond == 4'h0 |=> !o_count_wr
        && o_pc_next == $past(i_tdb_pc) + 32'h4) else $error("true condition wrong");
    branch_a: assert property (s_live ##0 i_cond == 4'h1 |=> o_count_wr
        && o_count_val == $past(i_count_lo) - 16'h1
        && o_pc_next == $past(i_tdb_pc) + 32'h2 + $past(disp_x)) else $error("branch wrong");
    irq_take_a: assert property (i_tdb_exec && i_irq_pending |=> o_irq_take && !o_loop_active)
        else $error("interrupt not taken");
    irq_cause_a: assert property (o_irq_take |-> $past(i_tdb_exec))
        else $error("interrupt taken off branch");
    refuse_a: assert property (i_tdb_exec && i_disp != LOOP_DISP && !o_loop_active
        |=> !o_loop_active) else $error("bad loop entry");
    resume_a: assert property ($fell(o_loop_active) |-> o_fetch_en)
        else $error("no fetch after exit");
    hold_ird_a: assert property (o_loop_active && $past(o_loop_active) |-> $stable(o_ird))
        else $error("decode word moved");
endmodule
bind slm_loop_ctrl slm_loop_properties slm_loop_properties_i (.i_clk, .i_rst_n, .i_tdb_exec,
    .i_count_lo, .i_cond, .i_disp, .i_tdb_pc, .i_irq_pending, .o_loop_active, .o_fetch_en,
    .o_count_wr, .o_count_val, .o_pc_next, .o_irq_take, .o_ird);
`default_nettype wire

// >>> tb/slm_mem_model.sv
// Purpose: Memory answering instruction fetches.
// Assumes: One word every second cycle while fetching is allowed.
// Notes:   Idle bus shows inverted data.
`timescale 1ns/1ps
`default_nettype none
module slm_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_fetch_en,
    output logic             o_fetch_valid,
    output logic [15:0]      o_fetch_word
);
    logic [15:0] addr_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_q        <= 16'h0000;
            o_fetch_valid <= 1'b0;
            o_fetch_word  <= 16'h0000;
        end else if (i_fetch_en && !o_fetch_valid) begin
            addr_q        <= addr_q + 16'h1;
            o_fetch_valid <= 1'b1;
            o_fetch_word  <= 16'hA000 + addr_q;
        end else begin
            o_fetch_valid <= 1'b0;
            o_fetch_word  <= ~o_fetch_word;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the loop controller.
// Assumes: Inputs change at the falling edge.
// Notes:   Conditions 0 and 1 avoid depending on flags.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import slm_pkg::*;
    logic i_clk, i_rst_n, i_tdb_exec, i_prev_loopable, i_prev_fetched;
    logic i_fetch_valid, i_irq_pending, i_abort, o_loop_active, o_fetch_en;
    logic o_count_wr, o_pc_load, o_irq_take;
    logic [15:0] i_count_lo, i_disp, i_fetch_word, o_count_val, o_ird, o_queue0, o_queue1;
    logic [31:0] i_tdb_pc, o_pc_next;
    logic [4:0]  i_ccr;
    logic [3:0]  i_cond;
    int failures, tests_run;
    slm_loop_ctrl slm_loop_ctrl_i (.i_clk, .i_rst_n, .i_tdb_exec, .i_count_lo, .i_cond,
        .i_disp, .i_tdb_pc, .i_ccr, .i_prev_loopable, .i_prev_fetched, .i_fetch_word,
        .i_fetch_valid, .i_irq_pending, .i_abort, .o_loop_active, .o_fetch_en, .o_count_wr,
        .o_count_val, .o_pc_load, .o_pc_next, .o_irq_take, .o_ird, .o_queue0, .o_queue1);
    slm_mem_model slm_mem_model_i (.i_clk, .i_rst_n, .i_fetch_en(o_fetch_en),
        .o_fetch_valid(i_fetch_valid), .o_fetch_word(i_fetch_word));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tdb(input logic [15:0] c, input logic [3:0] k, input logic [15:0] d,
                       input logic keep);
        if (!i_tdb_exec) @(negedge i_clk);
        {i_tdb_exec, i_count_lo, i_cond, i_disp} = {1'b1, c, k, d};
        @(negedge i_clk);
        if (!keep) i_tdb_exec = 1'b0;
    endtask
    task automatic wait_loop(input logic v);
        for (int n = 0; n < 20 && o_loop_active !== v; n++) @(negedge i_clk);
        check(o_loop_active, v);
    endtask
    task automatic enter;
        i_prev_loopable = 1'b1;
        tdb(16'h0008, 4'h1, LOOP_DISP, 1'b0);
        check(o_pc_next, i_tdb_pc - 32'h2);
        i_prev_fetched = 1'b1;
        wait_loop(1'b1);
        check(o_fetch_en, 1'b0);
        i_prev_fetched = 1'b0;
    endtask
    task automatic s_plain;
        tdb(16'h0000, 4'h1, 16'h0010, 1'b0);
        check({o_count_wr, o_count_val, o_pc_next}, {17'h1FFFF, i_tdb_pc + 32'h4});
        tdb(16'h0005, 4'h0, 16'h0010, 1'b0);
        check({o_count_wr, o_pc_next}, {1'b0, i_tdb_pc + 32'h4});
        i_tdb_pc = 32'h0000_2000;
        tdb(16'h0005, 4'h1, 16'h0010, 1'b0);
        check({o_count_val, o_pc_next}, {16'h0004, 32'h0000_2012});
        i_ccr = 5'h04;
        tdb(16'h0005, 4'h7, 16'h0010, 1'b0);
        check({o_count_wr, o_pc_load, o_pc_next}, {2'b01, 32'h0000_2004});
        i_ccr = 5'h00;
        tdb(16'h0005, 4'h7, 16'h0010, 1'b0);
        check({o_count_wr, o_pc_load, o_pc_next}, {2'b11, 32'h0000_2012});
    endtask
    task automatic s_loop;
        logic [15:0] ird;
        logic [31:0] que;
        enter();
        ird = o_ird;
        que = {o_queue0, o_queue1};
        tdb(16'h0007, 4'h1, LOOP_DISP, 1'b1);
        check({o_loop_active, o_count_val, o_ird}, {1'b1, 16'h0006, ird});
        check({o_queue0, o_queue1}, que);
        tdb(16'h0000, 4'h1, LOOP_DISP, 1'b0);
        check({o_loop_active, o_fetch_en, o_count_val}, {2'b01, 16'hFFFF});
    endtask
    task automatic s_irq_abort;
        i_irq_pending = 1'b1;
        repeat (3) @(negedge i_clk);
        check(o_irq_take, 1'b0);
        i_irq_pending = 1'b0;
        enter();
        i_irq_pending = 1'b1;
        tdb(16'h0007, 4'h1, LOOP_DISP, 1'b0);
        check({o_irq_take, o_loop_active}, 2'b10);
        i_irq_pending = 1'b0;
        enter();
        i_abort = 1'b1;
        @(negedge i_clk);
        i_abort = 1'b0;
        wait_loop(1'b0);
        check(o_fetch_en, 1'b1);
    endtask
    task automatic s_refuse;
        for (int k = 0; k < 2; k++) begin
            i_prev_loopable = k[0];
            tdb(16'h0008, 4'h1, k ? 16'hFFF8 : LOOP_DISP, 1'b0);
            i_prev_fetched = 1'b1;
            repeat (10) @(negedge i_clk);
            check(o_loop_active, 1'b0);
            i_prev_fetched = 1'b0;
        end
    endtask
    task automatic wrap_up;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
    initial begin
        {i_rst_n, i_tdb_exec, i_prev_loopable, i_prev_fetched, i_irq_pending, i_abort} = '0;
        {i_count_lo, i_cond, i_disp, i_ccr} = '0;
        i_tdb_pc = 32'h0000_1000;
        repeat (10) @(negedge i_clk);
        i_rst_n = 1'b1;
        check({o_fetch_en, o_loop_active}, 2'b10);
        s_plain();
        s_loop();
        s_irq_abort();
        s_refuse();
        wrap_up();
    end
endmodule
`default_nettype wire
